/* rtl/lock_guard_regs.vh */
// Purpose: Constants for the flash lock-region guard
// Assumes: Word-indexed register port, 100 MHz sys_clk
// Notes:   Offsets are register indices on the plain port
`ifndef LOCK_GUARD_REGS_VH
`define LOCK_GUARD_REGS_VH

`define OFS_MODE            4'h0
`define OFS_CMD             4'h1
`define OFS_STATUS          4'h2
`define OFS_LOCKS           4'h3

`define MODE_LOCK_ERROR_FLAG_IE_BIT   0
`define MODE_WS_LSB         8
`define MODE_WS_MSB         9
`define MODE_RESET          32'h00000000

`define CMD_CODE_LSB        0
`define CMD_CODE_MSB        3
`define CMD_PAGE_LSB        8
`define CMD_PAGE_MSB        17
`define CMD_KEY_LSB         24
`define CMD_KEY_MSB         31
`define CMD_KEY             8'h5A

`define CODE_PROGRAM        4'h1
`define CODE_SET_LOCK       4'h2
`define CODE_CLEAR_LOCK     4'h4
`define CODE_ERASE_ALL      4'h8

`define STAT_READY_BIT      0
`define STAT_LOCK_ERROR_FLAG_BIT      2
`define STAT_PROGE_BIT      3

`define OP_CYCLES           8'h10
`define LOCKS_RESET         16'h0000

`endif

/* rtl/read_wait_gen.v */
// Purpose: Flash read wait-state sequencer
// Assumes: Read request is a one-cycle pulse
// Notes:   Ack follows request by wait_states plus one cycle
`timescale 1ns/1ps

module read_wait_gen
(
	input  wire       sys_clk,
	input  wire       reset_n,
	input  wire [1:0] wait_states,
	input  wire       rd_req,
	output wire       rd_ack,
	output wire       busy
);

	reg  [1:0] count_q;
	reg        active_q;

	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			count_q  <= 2'h0;
			active_q <= 1'b0;
		end
		else if (rd_req && !active_q)
		begin
			count_q  <= wait_states;
			active_q <= 1'b1;
		end
		else if (active_q)
		begin
			if (count_q == 2'h0)
				active_q <= 1'b0;
			else
				count_q <= count_q - 2'h1;
		end
	end

	assign rd_ack = active_q && (count_q == 2'h0);
	assign busy   = active_q;

endmodule

/* rtl/flash_lock_region_guard.v */
// Purpose: Lock-region guard of the flash control unit
// Assumes: Core issues keyed single-write commands; erase pin synchronous
// Notes:   Flash array itself sits outside; this block gates its strobes
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "lock_guard_regs.vh"

module flash_lock_region_guard
#(
	parameter REGIONS      = 16,
	parameter PAGES        = 1024,
	parameter PAGE_BITS    = 10,
	parameter REGION_SHIFT = 6
)
(
	input  wire                 sys_clk,
	input  wire                 reset_n,
	input  wire [3:0]           reg_addr,
	input  wire [31:0]          reg_wdata,
	input  wire                 reg_wr,
	input  wire                 reg_rd,
	output reg  [31:0]          reg_rdata,
	input  wire                 erase_pin,
	input  wire                 flash_rd_req,
	output wire                 flash_rd_ack,
	output reg                  flash_prog_stb,
	output reg                  flash_erase_all_stb,
	output reg  [PAGE_BITS-1:0] flash_page,
	output reg                  nv_lock_wr_stb,
	output reg  [REGIONS-1:0]   nv_lock_wdata,
	output wire                 irq
);

	localparam ST_IDLE = 2'h0;
	localparam ST_BUSY = 2'h1;

	reg  [1:0]           state_q;
	reg  [7:0]           op_cnt_q;
	reg  [REGIONS-1:0]   lock_q;
	reg                  lock_error_flag_ie_q;
	reg  [1:0]           ws_q;
	reg                  lock_error_flag_q;
	reg                  proge_q;
	reg                  lock_error_flag_set;
	reg                  proge_set;
	reg                  start_op;
	reg  [REGIONS-1:0]   lock_d;

	wire [3:0]           cmd_code = reg_wdata[`CMD_CODE_MSB:`CMD_CODE_LSB];
	wire [PAGE_BITS-1:0] cmd_page = reg_wdata[`CMD_PAGE_LSB+PAGE_BITS-1:`CMD_PAGE_LSB];
	wire [7:0]           cmd_key  = reg_wdata[`CMD_KEY_MSB:`CMD_KEY_LSB];
	wire                 cmd_wr   = reg_wr && (reg_addr == `OFS_CMD);
	wire                 ready    = (state_q == ST_IDLE);

	// Region index from page number
	function [3:0] region_of;
		input [PAGE_BITS-1:0] page;
		begin
			region_of = page[PAGE_BITS-1:REGION_SHIFT];
		end
	endfunction

	wire [3:0] cmd_region = region_of(cmd_page);
	wire       region_locked = lock_q[cmd_region];

	// Command decode, all from one write
	always @*
	begin
		lock_error_flag_set = 1'b0;
		proge_set = 1'b0;
		start_op  = 1'b0;
		lock_d    = lock_q;
		if (erase_pin)
			lock_d = {REGIONS{1'b0}};
		else if (cmd_wr && ready)
		begin
			if (cmd_key != `CMD_KEY)
				proge_set = 1'b1;
			else if (cmd_code == `CODE_PROGRAM)
			begin
				if (region_locked)
					lock_error_flag_set = 1'b1;
				else
					start_op = 1'b1;
			end
			else if (cmd_code == `CODE_ERASE_ALL)
			begin
				if (|lock_q)
					lock_error_flag_set = 1'b1;
				else
					start_op = 1'b1;
			end
			else if (cmd_code == `CODE_SET_LOCK)
			begin
				lock_d[cmd_region] = 1'b1;
				start_op = 1'b1;
			end
			else if (cmd_code == `CODE_CLEAR_LOCK)
			begin
				lock_d[cmd_region] = 1'b0;
				start_op = 1'b1;
			end
			else
				proge_set = 1'b1;
		end
	end

	// Sequencer and lock image
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			state_q             <= ST_IDLE;
			op_cnt_q            <= 8'h00;
			lock_q              <= `LOCKS_RESET;
			flash_prog_stb      <= 1'b0;
			flash_erase_all_stb <= 1'b0;
			flash_page          <= {PAGE_BITS{1'b0}};
			nv_lock_wr_stb      <= 1'b0;
			nv_lock_wdata       <= {REGIONS{1'b0}};
		end
		else
		begin
			lock_q              <= lock_d;
			nv_lock_wr_stb      <= (lock_d != lock_q);
			nv_lock_wdata       <= lock_d;
			flash_prog_stb      <= start_op && (cmd_code == `CODE_PROGRAM) && !erase_pin;
			flash_erase_all_stb <= erase_pin || (start_op && (cmd_code == `CODE_ERASE_ALL));
			if (start_op)
				flash_page <= cmd_page;
			case (state_q)
				ST_IDLE:
				begin
					if (start_op)
					begin
						state_q  <= ST_BUSY;
						op_cnt_q <= `OP_CYCLES;
					end
				end
				ST_BUSY:
				begin
					if (op_cnt_q == 8'h00)
						state_q <= ST_IDLE;
					else
						op_cnt_q <= op_cnt_q - 8'h01;
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Mode register and sticky flags; set wins, read of status clears
	wire stat_rd = reg_rd && (reg_addr == `OFS_STATUS);

	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			lock_error_flag_ie_q <= 1'b0;
			ws_q       <= 2'h0;
			lock_error_flag_q    <= 1'b0;
			proge_q    <= 1'b0;
		end
		else
		begin
			if (reg_wr && (reg_addr == `OFS_MODE))
			begin
				lock_error_flag_ie_q <= reg_wdata[`MODE_LOCK_ERROR_FLAG_IE_BIT];
				ws_q       <= reg_wdata[`MODE_WS_MSB:`MODE_WS_LSB];
			end
			if (lock_error_flag_set)
				lock_error_flag_q <= 1'b1;
			else if (stat_rd)
				lock_error_flag_q <= 1'b0;
			if (proge_set)
				proge_q <= 1'b1;
			else if (stat_rd)
				proge_q <= 1'b0;
		end
	end

	assign irq = lock_error_flag_q && lock_error_flag_ie_q;

	// Register read port, data one cycle after strobe
	always @(posedge sys_clk)
	begin
		if (!reset_n)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
		begin
			if (reg_addr == `OFS_MODE)
				reg_rdata <= {22'h000000, ws_q, 7'h00, lock_error_flag_ie_q};
			else if (reg_addr == `OFS_STATUS)
				reg_rdata <= {28'h0000000, proge_q, lock_error_flag_q, 1'b0, ready};
			else if (reg_addr == `OFS_LOCKS)
				reg_rdata <= {{(32-REGIONS){1'b0}}, lock_q};
			else
				reg_rdata <= 32'h00000000;
		end
		else
			reg_rdata <= 32'h00000000;
	end

	read_wait_gen u_wait
	(
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.wait_states (ws_q),
		.rd_req      (flash_rd_req),
		.rd_ack      (flash_rd_ack),
		.busy        ()
	);

endmodule

/* tb/lock_guard_chk_asserts.sv */
// Purpose: Port checks of the lock guard
// Assumes: Lock image seen on store port
// Notes:   Bound into the guard
`timescale 1ns/1ps
module lock_guard_chk #(parameter REGIONS = 16, PAGE_BITS = 10)
(
	input wire logic sys_clk, reset_n, reg_wr, erase_pin, flash_rd_req,
	input wire logic flash_rd_ack, flash_prog_stb, nv_lock_wr_stb, irq, flash_erase_all_stb,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [PAGE_BITS-1:0] flash_page,
	input wire logic [REGIONS-1:0] nv_lock_wdata
);
	logic [REGIONS-1:0] lock_q;
	logic ie_q;
	wire req = reg_wr && reg_addr == 4'h1 && !erase_pin;
	wire cmd = req && reg_wdata[31:24] == 8'h5A;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	always @(posedge sys_clk)
	begin
		lock_q <= !reset_n ? '0 : nv_lock_wr_stb ? nv_lock_wdata : lock_q;
		ie_q <= reset_n && (reg_wr && reg_addr == 4'h0 ? reg_wdata[0] : ie_q);
	end
	chk_key_guard: assert property (req && !cmd |=> !flash_prog_stb && !nv_lock_wr_stb)
		else $error("keyless command acted");
	chk_locked_prog: assert property (cmd && reg_wdata[3:0] == 4'h1 && lock_q[reg_wdata[17:14]]
		|=> !flash_prog_stb) else $error("locked program ran");
	chk_prog_open: assert property (flash_prog_stb |-> !lock_q[flash_page[PAGE_BITS-1:6]])
		else $error("program in locked region");
	chk_lock_single: assert property (nv_lock_wr_stb && !$past(erase_pin)
		|-> $onehot(nv_lock_wdata ^ lock_q)) else $error("lock change not one region");
	chk_lock_source: assert property (nv_lock_wr_stb |-> $past(erase_pin || cmd))
		else $error("lock change without command");
	chk_erase_clear: assert property (nv_lock_wr_stb && $past(erase_pin) |-> nv_lock_wdata == '0)
		else $error("erase left locks");
	chk_irq_gate: assert property (irq |-> ie_q) else $error("irq while disabled");
	chk_erase_strobe: assert property (erase_pin |=> flash_erase_all_stb) else $error("erase pin no strobe");
	chk_read_wait: assert property (flash_rd_req |-> ##[1:4] flash_rd_ack)
		else $error("read ack late");
	cover property (irq);
	cover property (nv_lock_wr_stb && $past(erase_pin));
	cover property (flash_rd_ack);
endmodule
bind flash_lock_region_guard lock_guard_chk #(.REGIONS(REGIONS), .PAGE_BITS(PAGE_BITS)) chk (.*);

/* tb/flash_array_model.sv */
// Purpose: Flash array stand-in
// Assumes: One-cycle read requests
// Notes:   Counts programs, times reads
`timescale 1ns/1ps
module flash_array_model
(
	input  wire logic sys_clk, rd_go, flash_rd_ack, flash_prog_stb, flash_erase_all_stb,
	output logic      flash_rd_req = 0,
	output int        progs = 0, erases = 0, lat = 0
);
	int cnt;
	always @(posedge sys_clk)
	begin
		flash_rd_req <= rd_go;
		progs <= progs + flash_prog_stb;
		erases <= erases + flash_erase_all_stb;
		cnt <= flash_rd_req ? 1 : cnt + 1;
		if (flash_rd_ack)
			lat <= cnt;
	end
endmodule

/* tb/tb_flash_lock_region_guard.sv */
// Purpose: Self-checking bench of the lock guard
// Assumes: Commands done within 20 cycles
// Notes:   LFSR picks regions, pages, keys
`timescale 1ns/1ps
module tb_flash_lock_region_guard;
	logic sys_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, erase_pin = 0, rd_go = 0;
	logic flash_rd_req, flash_rd_ack, flash_prog_stb, flash_erase_all_stb, nv_lock_wr_stb, irq;
	logic [3:0] reg_addr = 0, r;
	logic [9:0] flash_page;
	logic [15:0] nv_lock_wdata, k, lfsr = 16'hCB27;
	logic [31:0] reg_wdata = 0, reg_rdata;
	int errors = 0, check_count = 0, progs, erases, lat, p0;
	flash_lock_region_guard dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.erase_pin(erase_pin), .flash_rd_req(flash_rd_req), .flash_rd_ack(flash_rd_ack),
		.flash_prog_stb(flash_prog_stb), .flash_erase_all_stb(flash_erase_all_stb),
		.flash_page(flash_page), .nv_lock_wr_stb(nv_lock_wr_stb), .nv_lock_wdata(nv_lock_wdata), .irq(irq));
	flash_array_model far (.sys_clk(sys_clk), .rd_go(rd_go), .flash_rd_ack(flash_rd_ack),
		.flash_prog_stb(flash_prog_stb), .flash_erase_all_stb(flash_erase_all_stb),
		.flash_rd_req(flash_rd_req), .progs(progs), .erases(erases), .lat(lat));
	initial forever #5 sys_clk = ~sys_clk;
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	task automatic check(logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge sys_clk);
		reg_wr <= 0;
		@(posedge sys_clk);
	endtask
	task automatic rd(logic [3:0] a, logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge sys_clk);
		reg_rd <= 0;
		#1 check(reg_rdata, e);
		@(posedge sys_clk);
	endtask
	task automatic cmd(logic [3:0] c, logic [9:0] p);
		wr(1, {8'h5A, 6'h00, p, 4'h0, c});
		repeat (20) @(posedge sys_clk);
	endtask
	task tally_and_finish();
		if (errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#100000;
		errors++;
		tally_and_finish();
	end
	initial
	begin
		repeat (5) @(posedge sys_clk);
		reset_n <= 1;
		@(posedge sys_clk);
		rd(3, 0);
		k = rnd();
		wr(1, {8'h5A ^ (k[7:0] | 8'h01), 16'h0000, 8'h01});
		rd(2, 32'h9);
		wr(0, 1);
		for (int i = 0; i < 4; i++)
		begin
			k = rnd();
			r = k[3:0];
			cmd(2, {r, k[9:4]});
			rd(3, 1 << r);
			p0 = progs;
			cmd(1, {r, 6'h3F});
			check(irq, 1);
			rd(2, 32'h5);
			cmd(1, {r + 4'h1, 6'h00});
			cmd(4, {r, k[15:10]});
			cmd(1, {r, 6'h00});
			check(progs, p0 + 2);
			rd(3, 0);
		end
		cmd(2, 10'h3C0);
		cmd(8, 0);
		rd(2, 32'h5);
		wr(0, 0);
		cmd(1, 10'h3FF);
		check(irq, 0);
		rd(2, 32'h5);
		p0 = erases;
		erase_pin <= 1;
		repeat (2) @(posedge sys_clk);
		erase_pin <= 0;
		repeat (2) @(posedge sys_clk);
		rd(3, 0);
		cmd(8, 0);
		check(erases, p0 + 3);
		for (int i = 0; i < 4; i++)
		begin
			wr(0, i << 8);
			rd_go <= 1;
			@(posedge sys_clk);
			rd_go <= 0;
			repeat (8) @(posedge sys_clk);
			check(lat, i + 1);
		end
		tally_and_finish();
	end
endmodule
